// ===== include/wdt_cfg.svh
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH
// Register byte offsets
`define ADR_CTRL 8'h00
`define ADR_TMO 8'h04
`define ADR_CMD 8'h08
`define ADR_STAT 8'h0C
`define ADR_MASK 8'h10
`define ADR_STATE 8'h14
// Control fields
`define F_POST 2:0
`define F_PAUSE 3
`define F_MODE 5:4
`define F_DELAY 8:6
`define F_EV1 10:9
`define F_EV2 12:11
`define F_EV3 14:13
`define F_RESTART 15
`define F_USERWAIT 16
`define CTRL_W 17
`define CTRL_RST 17'h0_0408
// Timeout fields, 4 bits per stage
`define F_TMO_W 4
`define TMO_RST 12'h0444
// Command bits
`define C_TRIG 0
`define C_DONE 1
// Status bits
`define S_POST 0
`define S_STG 1
`define STAT_W 4
// Durations in seconds
`define T_1S 11'h001
`define T_2S 11'h002
`define T_5S 11'h005
`define T_10S 11'h00A
`define T_30S 11'h01E
`define T_1M 11'h03C
`define T_2M 11'h078
`define T_5M 11'h12C
`define T_10M 11'h258
`define T_30M 11'h708
// Clock rate, 10 ns period
`define CLK_HZ 100000000
`endif

// ===== include/wdt_pkg.sv
package wdt_pkg;
    typedef enum logic [1:0] {ACT_NONE, ACT_ACPI, ACT_RESET, ACT_PWR} action_t;
    typedef enum logic [1:0] {MODE_OFF, MODE_ONCE, MODE_SINGLE, MODE_REPEAT} mode_t;
    typedef enum logic [1:0] {PH_POST, PH_DELAY, PH_RUN, PH_OFF} phase_t;
endpackage

// ===== verif/sys_event_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side sink: reset, power-button and ACPI logic
module sys_event_model (
    input wire logic clk_i,
    input wire logic sys_reset_i,
    input wire logic pwr_btn_i,
    input wire logic acpi_overtemp_i,
    input wire logic acpi_fatal_i
);
    int cyc = 0;
    int ev_id[$];
    int ev_t[$];
    // Log each request pulse: 0 reset, 1 power, 2 overtemp, 3 fatal
    // Stamped per edge so the bench can time stage spacing
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (sys_reset_i === 1'b1) begin
            ev_id.push_back(0);
            ev_t.push_back(cyc);
        end
        if (pwr_btn_i === 1'b1) begin
            ev_id.push_back(1);
            ev_t.push_back(cyc);
        end
        if (acpi_overtemp_i === 1'b1) begin
            ev_id.push_back(2);
            ev_t.push_back(cyc);
        end
        if (acpi_fatal_i === 1'b1) begin
            ev_id.push_back(3);
            ev_t.push_back(cyc);
        end
    end
endmodule // sys_event_model
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"
module testbench;
    import wdt_pkg::*;
    localparam int CLK = 10;
    // Each timer restart costs the seconds divider one extra cycle
    localparam int LAT = 1;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic [7:0] adr = 0;
    logic [3:0] sel = 0;
    logic [31:0] wdat = 0, rdat, q;
    logic ack, sys_reset, pwr_btn, ovt, fatal, irq;
    int err_total = 0;
    int checked = 0;
    int ticks = 0;
    int t0;
    logic [31:0] seed = 32'h3805_f344;
    logic [11:0] tm;
    sys_watchdog #(.CLK_HZ(CLK)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .sys_reset_o(sys_reset), .pwr_btn_o(pwr_btn),
        .acpi_overtemp_o(ovt), .acpi_fatal_o(fatal), .irq_o(irq));
    sys_event_model u_model (.clk_i(clk_i), .sys_reset_i(sys_reset), .pwr_btn_i(pwr_btn),
        .acpi_overtemp_i(ovt), .acpi_fatal_i(fatal));
    // 100 MHz clock
    always #5 clk_i = ~clk_i;
    // Hang guard, tests need well under 8000 cycles
    always @(posedge clk_i) begin
        ticks <= ticks + 1;
        if (ticks == 20000) begin
            err_total = err_total + 1;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Timeout code to seconds, ten steps
    function automatic int secs(input logic [3:0] c);
        int t[9] = '{1, 2, 5, 10, 30, 60, 120, 300, 600};
        return (c > 8) ? 1800 : t[c];
    endfunction
    // Classic cycle; request held until the edge that samples ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dd);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= dd;
        sel <= 4'hF;
        // Ack and read data judged at the rising edge; only the hang guard ends a wait
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        u_model.ev_id.delete();
        u_model.ev_t.delete();
    endtask
    task automatic wait_ev(input int n, input int lim);
        int k;
        k = 0;
        while (u_model.ev_id.size() < n && k < lim) begin
            @(negedge clk_i);
            k++;
        end
    endtask
    // Reset, configure, then end boot to arm the runtime timer
    task automatic rt_start(input logic [31:0] c, input logic [31:0] t);
        do_reset();
        wb(1, `ADR_CTRL, c);
        wb(1, `ADR_TMO, t);
        wb(1, `ADR_CMD, 32'h0000_0002);
        t0 = u_model.cyc;
    endtask
    initial begin
        do_reset();
        wb(0, `ADR_CTRL, 0);
        chk(q, 32'h0000_0408);
        wb(0, `ADR_TMO, 0);
        chk(q, 32'h0000_0444);
        wb(0, 8'h3C, 0);
        chk(q, 32'h0);
        wb(1, `ADR_CTRL, 32'h0);
        wb(0, `ADR_CTRL, 0);
        chk(q, 32'h0000_0400);
        repeat (400) @(posedge clk_i);
        chk(u_model.ev_id.size(), 0);
        wb(1, `ADR_CTRL, 32'h0001_0009);
        repeat (400) @(posedge clk_i);
        chk(u_model.ev_id.size(), 0);
        wb(1, `ADR_CTRL, 32'h0000_0009);
        wait_ev(1, 400);
        chk(u_model.ev_id.size(), 1);
        chk(u_model.ev_id[0], 0);
        wb(1, `ADR_MASK, 32'h1);
        repeat (2) @(posedge clk_i);
        chk(irq, 1'b1);
        $display("test boot done");
        // Single mode, 10 s delay, random stage timeouts
        repeat (2) begin
            seed = xs(seed);
            tm = {4'(seed[11:8] % 3), 4'(seed[7:4] % 3), 4'(seed[3:0] % 3)};
            rt_start(32'h0000_5A60, 32'(tm));
            wait_ev(3, 2000);
            chk(u_model.ev_id.size(), 3);
            chk(u_model.ev_id[0], 2);
            chk(u_model.ev_id[1], 1);
            chk(u_model.ev_id[2], 0);
            // Boot done and the end of the delay are two restarts before stage one
            chk(u_model.ev_t[0] - t0, CLK * (10 + secs(tm[3:0])) + 2 * LAT);
            chk(u_model.ev_t[1] - u_model.ev_t[0], CLK * secs(tm[7:4]) + LAT);
            chk(u_model.ev_t[2] - u_model.ev_t[1], CLK * secs(tm[11:8]) + LAT);
            repeat (600) @(posedge clk_i);
            chk(u_model.ev_id.size(), 3);
            wb(0, `ADR_STATE, 0);
            chk(q[1:0], 2'd3);
            chk(irq, 1'b0);
            wb(1, `ADR_MASK, 32'h2);
            repeat (2) @(posedge clk_i);
            chk(irq, 1'b1);
            wb(0, `ADR_STAT, 0);
            chk(q, 32'hE);
            repeat (2) @(posedge clk_i);
            chk(irq, 1'b0);
            $display("test single done");
        end
        // Repeated mode, stage two silent, ACPI restart on stage three
        rt_start(32'h0000_A430, 32'h0);
        wait_ev(5, 400);
        chk(u_model.ev_id.size(), 5);
        chk(u_model.ev_id[0], 0);
        for (int i = 1; i < 5; i++) chk(u_model.ev_id[i], 3);
        chk(u_model.ev_t[1] - u_model.ev_t[0], 2 * (CLK + LAT));
        chk(u_model.ev_t[3] - u_model.ev_t[2], CLK + LAT);
        $display("test repeated done");
        // Once mode: first trigger switches the timer off
        rt_start(32'h0000_0210, 32'h3);
        repeat (30) @(posedge clk_i);
        wb(1, `ADR_CMD, 32'h1);
        repeat (300) @(posedge clk_i);
        chk(u_model.ev_id.size(), 0);
        wb(0, `ADR_STATE, 0);
        chk(q[1:0], 2'd3);
        $display("test once done");
        // Mode off: boot done leaves the runtime timer switched off
        rt_start(32'h0000_0400, 32'h0);
        repeat (50) @(posedge clk_i);
        chk(u_model.ev_id.size(), 0);
        wb(0, `ADR_STATE, 0);
        chk(q[1:0], 2'd3);
        $display("test off done");
        // Periodic triggers keep stage one from firing
        rt_start(32'h0000_0430, 32'h1);
        repeat (14) wb(1, `ADR_CMD, 32'h1);
        chk(u_model.ev_id.size(), 0);
        t0 = u_model.cyc;
        wait_ev(1, 100);
        chk(u_model.ev_id.size(), 1);
        chk(u_model.ev_id[0], 0);
        chk(u_model.ev_t[0] - t0, 2 * CLK + LAT);
        $display("test trigger done");
        print_verdict();
    end
endmodule // testbench
`default_nettype wire

// ===== verilog/sec_tick.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"
// One-cycle enable once per second, restartable
module sec_tick #(
    parameter int CYCLES = `CLK_HZ
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clr_i,
    output logic tick_o
);
    localparam int W = $clog2(CYCLES);
    logic [W-1:0] div;

    // Restart aligns every timeout to the event that began it
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            div <= '0;
            tick_o <= 1'b0;
        end else if (div == W'(CYCLES - 1)) begin
            div <= '0;
            tick_o <= 1'b1;
        end else begin
            div <= div + 1'b1;
            tick_o <= 1'b0;
        end
    end
endmodule // sec_tick
`default_nettype wire

// ===== verilog/sys_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"
// Notes on behaviour
// - Boot timer: off, 30 s, 1, 2, 5, 10, 30 min; off after reset.
// - Boot timer counts only before boot completes; expiry forces system reset.
// - With pause set, boot timer holds while user input is awaited.
// - Runtime timer arms at boot completion; modes off, once, single, repeated.
// - Once mode: first software trigger switches the runtime timer off.
// - Single mode: stages run once in order, then timer switches off.
// - Repeated mode: last stage runs again and again until reset or a software trigger restarts stage one.
// - Runtime start delay: none, 10 s, 30 s, 1, 2, 5, 10, 30 min.
// - Stage one expiry raises ACPI, reset (default) or power-button action.
// - Stage two and three raise none (default), ACPI, reset or power button.
// - Stage one timeout 1 s to 30 min from ten choices, 30 s default.
// - Stage two and three timeouts chosen independently from the same set.
// - ACPI action selects orderly shutdown (default) or orderly restart.
// - ACPI shutdown signals an over-temperature notification.
// - ACPI restart signals a fatal error condition.
// - No NMI action exists; no path to the processor for one.
module sys_watchdog
    import wdt_pkg::*;
#(
    parameter int CLK_HZ = `CLK_HZ
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic sys_reset_o,
    output logic pwr_btn_o,
    output logic acpi_overtemp_o,
    output logic acpi_fatal_o,
    output logic irq_o
);
    logic [`CTRL_W-1:0] ctrl;
    logic [11:0] tmo;
    logic [`STAT_W-1:0] stat;
    logic [`STAT_W-1:0] mask;
    phase_t phase;
    logic [1:0] stage;
    logic [10:0] cnt;
    logic tick;
    logic req, wr, rd;
    logic trig, done;
    logic run_count, expire, fire;
    logic [10:0] limit;
    action_t act;
    mode_t mode;

    // Stage timeout table; unused codes act as the longest time
    function automatic logic [10:0] stage_secs(input logic [3:0] sel);
        unique case (sel)
            4'h0: stage_secs = `T_1S;
            4'h1: stage_secs = `T_2S;
            4'h2: stage_secs = `T_5S;
            4'h3: stage_secs = `T_10S;
            4'h4: stage_secs = `T_30S;
            4'h5: stage_secs = `T_1M;
            4'h6: stage_secs = `T_2M;
            4'h7: stage_secs = `T_5M;
            4'h8: stage_secs = `T_10M;
            default: stage_secs = `T_30M;
        endcase
    endfunction

    // Boot timer table; code 0 means off
    function automatic logic [10:0] post_secs(input logic [2:0] sel);
        unique case (sel)
            3'h1: post_secs = `T_30S;
            3'h2: post_secs = `T_1M;
            3'h3: post_secs = `T_2M;
            3'h4: post_secs = `T_5M;
            3'h5: post_secs = `T_10M;
            default: post_secs = `T_30M;
        endcase
    endfunction

    // Start delay table; code 0 means none
    function automatic logic [10:0] delay_secs(input logic [2:0] sel);
        unique case (sel)
            3'h1: delay_secs = `T_10S;
            3'h2: delay_secs = `T_30S;
            3'h3: delay_secs = `T_1M;
            3'h4: delay_secs = `T_2M;
            3'h5: delay_secs = `T_5M;
            3'h6: delay_secs = `T_10M;
            default: delay_secs = `T_30M;
        endcase
    endfunction

    // Bus decode; ack pulses one cycle after request
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i;
    assign rd = req && !wb_we_i;
    assign trig = wr && wb_adr_i == `ADR_CMD && wb_sel_i[0] && wb_dat_i[`C_TRIG] &&
        phase == PH_RUN; // A stray trigger must not hold off the boot timer
    assign done = wr && wb_adr_i == `ADR_CMD && wb_sel_i[0] && wb_dat_i[`C_DONE] &&
        phase == PH_POST; // Later writes must not act as a hidden trigger
    assign mode = mode_t'(ctrl[`F_MODE]);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // Configuration writes, byte enables honoured
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= `CTRL_RST;
            tmo <= `TMO_RST;
            mask <= '0;
        end else if (wr) begin
            if (wb_adr_i == `ADR_CTRL) begin
                if (wb_sel_i[0]) ctrl[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) begin
                    ctrl[15:8] <= wb_dat_i[15:8];
                    // Stage one has no "none" choice; fall back to reset
                    if (wb_dat_i[`F_EV1] == 2'(ACT_NONE)) ctrl[`F_EV1] <= 2'(ACT_RESET);
                end
                if (wb_sel_i[2]) ctrl[`F_USERWAIT] <= wb_dat_i[`F_USERWAIT];
            end
            if (wb_adr_i == `ADR_TMO) begin
                if (wb_sel_i[0]) tmo[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) tmo[11:8] <= wb_dat_i[11:8];
            end
            if (wb_adr_i == `ADR_MASK && wb_sel_i[0]) mask <= wb_dat_i[`STAT_W-1:0];
        end
    end

    // Read data, unmapped offsets read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (rd) begin
            unique case (wb_adr_i)
                `ADR_CTRL: wb_dat_o <= 32'(ctrl);
                `ADR_TMO: wb_dat_o <= 32'(tmo);
                `ADR_STAT: wb_dat_o <= 32'(stat);
                `ADR_MASK: wb_dat_o <= 32'(mask);
                `ADR_STATE: wb_dat_o <= {16'h0000, cnt, 1'b0, stage, phase};
                default: wb_dat_o <= '0;
            endcase
        end else begin
            wb_dat_o <= '0;
        end
    end

    // Seconds base, restarted on every timer restart
    sec_tick #(.CYCLES(CLK_HZ)) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(trig || done || expire),
        .tick_o(tick)
    );

    // Limit of the running count
    always_comb begin
        unique case (phase)
            PH_POST: limit = post_secs(ctrl[`F_POST]);
            PH_DELAY: limit = delay_secs(ctrl[`F_DELAY]);
            default: limit = stage_secs(tmo[stage*`F_TMO_W +: `F_TMO_W]);
        endcase
    end

    // Boot timer may pause for user input; runtime counts freely
    always_comb begin
        unique case (phase)
            PH_POST: run_count = tick && ctrl[`F_POST] != 3'h0 &&
                !(ctrl[`F_PAUSE] && ctrl[`F_USERWAIT]);
            PH_DELAY, PH_RUN: run_count = tick;
            default: run_count = 1'b0;
        endcase
    end
    assign expire = run_count && cnt == limit - 11'h001;
    assign fire = expire && phase == PH_RUN;

    // Action of the stage that fires; no NMI choice exists
    always_comb begin
        unique case (stage)
            2'h0: act = action_t'(ctrl[`F_EV1]);
            2'h1: act = action_t'(ctrl[`F_EV2]);
            default: act = action_t'(ctrl[`F_EV3]);
        endcase
    end

    // Phase and stage sequencing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase <= PH_POST;
            stage <= 2'h0;
        end else begin
            unique case (phase)
                PH_POST: begin
                    if (expire) begin
                        phase <= PH_OFF;
                    end else if (done) begin
                        // Arm just before the OS boots
                        if (mode == MODE_OFF) phase <= PH_OFF;
                        else if (ctrl[`F_DELAY] == 3'h0) phase <= PH_RUN;
                        else phase <= PH_DELAY;
                        stage <= 2'h0;
                    end
                end
                PH_DELAY: begin
                    if (expire) phase <= PH_RUN;
                end
                PH_RUN: begin
                    if (trig && mode == MODE_ONCE) begin
                        phase <= PH_OFF;
                    end else if (trig) begin
                        stage <= 2'h0;
                    end else if (fire) begin
                        if (stage != 2'h2) stage <= stage + 2'h1;
                        else if (mode != MODE_REPEAT) phase <= PH_OFF;
                    end
                end
                default: phase <= PH_OFF;
            endcase
        end
    end

    // Seconds counter, cleared at each restart
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= '0;
        end else if (trig || done || expire) begin
            cnt <= '0;
        end else if (run_count) begin
            cnt <= cnt + 11'h001;
        end
    end

    // Action outputs, one-cycle pulses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_reset_o <= 1'b0;
            pwr_btn_o <= 1'b0;
            acpi_overtemp_o <= 1'b0;
            acpi_fatal_o <= 1'b0;
        end else begin
            sys_reset_o <= (expire && phase == PH_POST) || (fire && act == ACT_RESET);
            pwr_btn_o <= fire && act == ACT_PWR;
            acpi_overtemp_o <= fire && act == ACT_ACPI && !ctrl[`F_RESTART];
            acpi_fatal_o <= fire && act == ACT_ACPI && ctrl[`F_RESTART];
        end
    end

    // Sticky status; a new event beats the clear-on-read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat <= '0;
        end else begin
            for (int i = 0; i < `STAT_W; i++) begin
                if ((i == `S_POST && expire && phase == PH_POST) ||
                    (i != `S_POST && fire && 32'(stage) == i - `S_STG)) begin
                    stat[i] <= 1'b1;
                end else if (rd && wb_adr_i == `ADR_STAT) begin
                    stat[i] <= 1'b0;
                end
            end
        end
    end
    // Level interrupt, one cycle behind the status bits
    always_ff @(posedge clk_i) begin
        if (rst_i) irq_o <= 1'b0;
        else irq_o <= |(stat & mask);
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence run_once_trig;
        phase == PH_RUN && trig && mode == MODE_ONCE;
    endsequence
    sequence last_fire;
        fire && stage == 2'h2 && !trig;
    endsequence
    post_reset_a: assert property (expire && phase == PH_POST
        |=> sys_reset_o && phase == PH_OFF)
        else $error("boot expiry without reset");
    post_pause_a: assert property (phase == PH_POST && ctrl[`F_PAUSE] &&
        ctrl[`F_USERWAIT] && !done |=> $stable(cnt))
        else $error("boot timer counted while paused");
    post_off_a: assert property (phase == PH_POST && ~|ctrl[`F_POST] |=> !sys_reset_o)
        else $error("disabled boot timer fired");
    arm_delay_a: assert property (phase == PH_POST && done && !expire &&
        mode != MODE_OFF && ctrl[`F_DELAY] != 3'h0 |=> phase == PH_DELAY && cnt == 11'h000)
        else $error("delay not entered");
    once_off_a: assert property (run_once_trig |=> phase == PH_OFF ##1 !pwr_btn_o)
        else $error("once mode not disabled");
    single_end_a: assert property (last_fire and mode == MODE_SINGLE |=> phase == PH_OFF)
        else $error("single mode kept running");
    repeat_last_a: assert property (last_fire and mode == MODE_REPEAT
        |=> phase == PH_RUN && stage == 2'h2)
        else $error("repeat mode left last stage");
    trig_restart_a: assert property (phase == PH_RUN && trig && mode != MODE_ONCE
        |=> stage == 2'h0 && cnt == 11'h000)
        else $error("trigger did not restart stage one");
    acpi_kind_a: assert property (fire && act == ACT_ACPI
        |=> acpi_overtemp_o != acpi_fatal_o && acpi_fatal_o == $past(ctrl[`F_RESTART]))
        else $error("wrong ACPI notification");
    stage_act_a: assert property (fire && stage == 2'h0 |=> (sys_reset_o || pwr_btn_o ||
        acpi_overtemp_o || acpi_fatal_o))
        else $error("stage one fired no action");
    none_act_a: assert property (fire && act == ACT_NONE |=> !sys_reset_o && !pwr_btn_o)
        else $error("none action drove output");
    bus_ack_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not single pulse");
endmodule // sys_watchdog
`default_nettype wire
